// ==== shared/flash_protect_defs.vh ====
// Constants for the flash sector write-protect block
//
// How it works
// [R1] Subsectors are aligned 4KB address ranges
// [R2] Modifying commands need whole-byte clock counts
// [R3] Write enable latch must be set first
// [R4] Sector write-lock bit blocks program/erase
// [R5] Lock-down freezes write-lock until reset
// [R6] Lock bits change only by lock-write command
// [R7] Top select zero protects upper sectors
// [R8] Top select one protects lower sectors
// [R9] Write-protect pin low freezes protect bits; the code ignores the pin while quad_mode is high
// [R10] Geometry: 64 sectors, 1024 subsectors, 256B pages
// [R11] Any protected covered sector refuses the request
// [R12] Reset clears all lock and lock-down bits
`ifndef FLASH_PROTECT_DEFS_VH
`define FLASH_PROTECT_DEFS_VH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define SECTOR_LSB      16
`define SECTOR_MSB      21
`define SUBSECTOR_LSB   12
`define SECTOR_COUNT    64
`define LAST_SECTOR     6'h3f

// ----------------------------------------------------------------
// Command opcodes on the request port
// ----------------------------------------------------------------
`define OP_WRITE_ENABLE   3'h0
`define OP_WRITE_DISABLE  3'h1
`define OP_PROGRAM        3'h2
`define OP_SUBSECT_ERASE  3'h3
`define OP_SECTOR_ERASE   3'h4
`define OP_BULK_ERASE     3'h5
`define OP_WRITE_STATUS   3'h6
`define OP_WRITE_LOCK     3'h7

// ----------------------------------------------------------------
// Verdict reason codes
// ----------------------------------------------------------------
`define WHY_OK        3'h0
`define WHY_FRAMING   3'h1
`define WHY_NO_WEL    3'h2
`define WHY_LOCKED    3'h3
`define WHY_AREA      3'h4
`define WHY_WP_PIN    3'h5
`define WHY_LOCKDOWN  3'h6

// ----------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------
`define REG_STATUS    4'h0
`define REG_LOCK_SEL  4'h4
`define REG_LOCK_VIEW 4'h8
`define REG_VERDICT   4'hc
`define REG_CTRL      4'h0
`define CTRL_OFFSET   4'h0
`define REG_CONTROL   4'h0
`define CTRL_ADDR     5'h10
`define CTRL_WP_EN    0
`define CTRL_RESET    1'h1
`define LOCK_WL_BIT   0
`define LOCK_LD_BIT   1

`endif

// ==== hw/sector_region_check.v ====
// Block-protect region decode over a range of sectors
`timescale 1ns/1ps
`default_nettype none
module sector_region_check (
  input  wire [2:0] size_code,
  input  wire       from_bottom,
  input  wire [5:0] first_sector,
  input  wire [5:0] last_sector,
  output reg        hit
);
  reg [6:0] count;
  reg [6:0] bound;

  // ----------------------------------------------------------------
  // Number of protected sectors, then overlap with the range
  // ----------------------------------------------------------------
  always @* begin
    count = 7'h00;
    bound = 7'h00;
    hit   = 1'b0;
    case (size_code)
      3'h0: count = 7'h00;
      3'h7: count = 7'h40;
      default: count = 7'h01 << (size_code - 3'h1);
    endcase
    if (count != 7'h00) begin
      if (from_bottom) begin
        hit = {1'b0, first_sector} < count; // [R8]
      end else begin
        bound = 7'h40 - count;
        hit = {1'b0, last_sector} >= bound; // [R7]
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/flash_sector_write_protect.v ====
// Write-protect decision and sector lock state for the serial flash
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_defs.vh"
module flash_sector_write_protect #(
  parameter ADDR_W = 24
) (
  input  wire              core_clk,
  input  wire              rst_n,
  // Command request from the protocol engine
  input  wire              cmd_valid,
  input  wire [2:0]        cmd_op,
  input  wire [ADDR_W-1:0] cmd_addr,
  input  wire [15:0]       cmd_bits,
  input  wire [7:0]        cmd_data,
  input  wire              quad_mode,
  input  wire              wp_pin_n,
  // Verdict
  output reg               verdict_valid,
  output reg               verdict_grant,
  output reg  [2:0]        verdict_reason,
  output reg  [2:0]        verdict_op,
  output reg  [9:0]        verdict_subsector,
  output reg               write_enable_latch,
  output reg               protect_size_bit0,
  output reg               protect_size_bit1,
  output reg               protect_size_bit2,
  output reg               top_bottom,
  // Register port
  input  wire [4:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [7:0]        reg_rdata
);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  reg wp_meta;
  reg wp_sync;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
    end else begin
      wp_meta <= wp_pin_n;
      wp_sync <= wp_meta;
    end
  end

  // ----------------------------------------------------------------
  // Sector range of the request
  // ----------------------------------------------------------------
  wire [5:0] cmd_sector    = cmd_addr[`SECTOR_MSB:`SECTOR_LSB]; // [R10]
  wire [9:0] cmd_subsector = cmd_addr[`SECTOR_MSB:`SUBSECTOR_LSB]; // [R1]
  wire       is_bulk       = (cmd_op == `OP_BULK_ERASE);
  wire [5:0] first_sector  = is_bulk ? 6'h00 : cmd_sector;
  wire [5:0] last_sector   = is_bulk ? `LAST_SECTOR : cmd_sector;

  reg  [63:0] write_lock;
  reg  [63:0] lock_down;
  wire [63:0] covered;

  genvar i;
  generate
    for (i = 0; i < `SECTOR_COUNT; i = i + 1) begin : g_cover
      localparam [5:0] IDX = i;
      assign covered[i] = (IDX >= first_sector) &&
                          (IDX <= last_sector);
    end
  endgenerate

  wire lock_hit = |(write_lock & covered); // [R4] [R11]
  wire area_hit;

  sector_region_check u_region (
    .size_code    ({protect_size_bit2, protect_size_bit1,
                    protect_size_bit0}),
    .from_bottom  (top_bottom),
    .first_sector (first_sector),
    .last_sector  (last_sector),
    .hit          (area_hit)
  );

  // ----------------------------------------------------------------
  // Verdict logic
  // ----------------------------------------------------------------
  wire is_array  = (cmd_op == `OP_PROGRAM) ||
                   (cmd_op == `OP_SUBSECT_ERASE) ||
                   (cmd_op == `OP_SECTOR_ERASE) || is_bulk;
  wire is_modify = is_array || (cmd_op == `OP_WRITE_STATUS) ||
                   (cmd_op == `OP_WRITE_LOCK);
  reg  wp_enable;
  // Quad protocol uses the pin as data, so it cannot protect then
  wire wp_active = wp_enable && !wp_sync && !quad_mode;

  reg [2:0] next_reason;
  always @* begin
    next_reason = `WHY_OK;
    if (is_modify) begin
      if (cmd_bits[2:0] != 3'h0)
        next_reason = `WHY_FRAMING; // [R2]
      else if (!write_enable_latch)
        next_reason = `WHY_NO_WEL; // [R3]
      else if (is_array && lock_hit)
        next_reason = `WHY_LOCKED; // [R4]
      else if (is_array && area_hit)
        next_reason = `WHY_AREA; // [R7] [R8] [R11]
      else if (cmd_op == `OP_WRITE_STATUS && wp_active)
        next_reason = `WHY_WP_PIN; // [R9]
      else if (cmd_op == `OP_WRITE_LOCK && lock_down[cmd_sector])
        next_reason = `WHY_LOCKDOWN; // [R5] [R6]
    end
  end

  wire grant = (next_reason == `WHY_OK);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      verdict_valid      <= 1'b0;
      verdict_grant      <= 1'b0;
      verdict_reason     <= `WHY_OK;
      verdict_op         <= `OP_WRITE_ENABLE;
      verdict_subsector  <= 10'h000;
      write_enable_latch <= 1'b0;
      protect_size_bit0  <= 1'b0;
      protect_size_bit1  <= 1'b0;
      protect_size_bit2  <= 1'b0;
      top_bottom         <= 1'b0;
      write_lock         <= 64'h0000000000000000; // [R12]
      lock_down          <= 64'h0000000000000000; // [R12]
    end else begin
      verdict_valid <= cmd_valid;
      if (cmd_valid) begin
        verdict_grant     <= grant;
        verdict_reason    <= next_reason;
        verdict_op        <= cmd_op;
        verdict_subsector <= cmd_subsector;
        case (cmd_op)
          `OP_WRITE_ENABLE: begin
            write_enable_latch <= 1'b1; // [R3]
          end
          `OP_WRITE_DISABLE: begin
            write_enable_latch <= 1'b0;
          end
          `OP_WRITE_STATUS: begin
            if (grant) begin
              protect_size_bit0 <= cmd_data[2];
              protect_size_bit1 <= cmd_data[3];
              protect_size_bit2 <= cmd_data[4];
              top_bottom        <= cmd_data[5];
            end
          end
          `OP_WRITE_LOCK: begin
            if (grant) begin
              write_lock[cmd_sector] <= cmd_data[`LOCK_WL_BIT]; // [R6]
              lock_down[cmd_sector]  <= cmd_data[`LOCK_LD_BIT]; // [R5]
            end
          end
          default: begin
          end
        endcase
        // An executed modify command consumes the latch
        if (is_modify && grant)
          write_enable_latch <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  reg [5:0] lock_sel;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      lock_sel  <= 6'h00;
      wp_enable <= `CTRL_RESET;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr) begin
        if (reg_addr == {1'b0, `REG_LOCK_SEL})
          lock_sel <= reg_wdata[5:0];
        if (reg_addr == `CTRL_ADDR)
          wp_enable <= reg_wdata[`CTRL_WP_EN];
      end
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          {1'b0, `REG_STATUS}:
            reg_rdata <= {2'h0, top_bottom, protect_size_bit2,
                          protect_size_bit1, protect_size_bit0,
                          wp_sync, write_enable_latch};
          {1'b0, `REG_LOCK_SEL}:
            reg_rdata <= {2'h0, lock_sel};
          {1'b0, `REG_LOCK_VIEW}:
            reg_rdata <= {6'h00, lock_down[lock_sel],
                          write_lock[lock_sel]};
          {1'b0, `REG_VERDICT}:
            reg_rdata <= {1'b0, verdict_op, verdict_grant,
                          verdict_reason};
          `CTRL_ADDR:
            reg_rdata <= {7'h00, wp_enable};
          default:
            reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ==== bench/flash_protect_properties.sv ====
// Concurrent checks on the flash write-protect block ports
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_defs.vh"
module flash_protect_checker #(
  parameter ADDR_W = 24
) (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              cmd_valid,
  input wire logic [2:0]        cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [15:0]       cmd_bits,
  input wire logic              verdict_valid,
  input wire logic              verdict_grant,
  input wire logic [2:0]        verdict_reason,
  input wire logic [2:0]        verdict_op,
  input wire logic [9:0]        verdict_subsector,
  input wire logic              write_enable_latch,
  input wire logic              protect_size_bit0,
  input wire logic              protect_size_bit1,
  input wire logic              protect_size_bit2,
  input wire logic              top_bottom
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic [2:0] sz = {protect_size_bit2, protect_size_bit1,
                         protect_size_bit0};
  wire logic       go = cmd_valid && cmd_op >= `OP_PROGRAM &&
                        cmd_bits[2:0] == 3'h0;
  // Size 0 gives n of 0, so neither compare below can hit
  wire logic [6:0] n = (sz == 3'h7) ? 7'h40 :
                       (sz == 3'h0) ? 7'h00 : 7'h01 << (sz - 3'h1);
  wire logic [6:0] s = {1'b0, cmd_addr[21:16]};
  wire logic       hit = top_bottom ? (s < n) : (s >= 7'h40 - n);
  property p_echo; cmd_valid |=> verdict_valid &&
    verdict_subsector == $past(cmd_addr[21:12]); endproperty
  a_echo: assert property (p_echo) else $error("verdict echo wrong");
  property p_frame; cmd_valid && cmd_op >= `OP_PROGRAM && cmd_bits[2:0] !=
    3'h0 |=> !verdict_grant && verdict_reason == `WHY_FRAMING; endproperty
  a_frame: assert property (p_frame) else $error("partial byte ran");
  property p_wel; go && !write_enable_latch |=>
    !verdict_grant && verdict_reason == `WHY_NO_WEL; endproperty
  a_wel: assert property (p_wel) else $error("ran without latch");
  property p_wren; cmd_valid && cmd_op == `OP_WRITE_ENABLE |=>
    write_enable_latch && verdict_grant; endproperty
  a_wren: assert property (p_wren) else $error("latch not set");
  property p_clear; verdict_valid && verdict_grant &&
    verdict_op >= `OP_PROGRAM |-> !write_enable_latch; endproperty
  a_clear: assert property (p_clear) else $error("latch kept");
  property p_area; go && write_enable_latch && (cmd_op == `OP_BULK_ERASE ?
    sz != 3'h0 : cmd_op < `OP_WRITE_STATUS && hit) |=> !verdict_grant;
  endproperty
  a_area: assert property (p_area) else $error("area write ran");
  property p_bp; !(verdict_valid && verdict_grant && verdict_op ==
    `OP_WRITE_STATUS) |-> $stable(sz) && $stable(top_bottom); endproperty
  a_bp: assert property (p_bp) else $error("protect bits moved");
  property p_reset; $rose(rst_n) |->
    !write_enable_latch && !verdict_valid && sz == 3'h0; endproperty
  a_reset: assert property (p_reset) else $error("reset state");
endmodule
bind flash_sector_write_protect flash_protect_checker #(
  .ADDR_W(ADDR_W)) u_flash_protect_checker (.*);
`default_nettype wire

// ==== bench/spi_host_model.sv ====
// Command source standing in for the SPI host controller
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic        core_clk,
  output var  logic        cmd_valid,
  output var  logic [2:0]  cmd_op,
  output var  logic [23:0] cmd_addr,
  output var  logic [15:0] cmd_bits,
  output var  logic [7:0]  cmd_data
);
  initial {cmd_valid, cmd_op, cmd_addr, cmd_bits, cmd_data} = '0;
  task automatic issue(input logic [2:0] op, input logic [23:0] a,
                       input logic [15:0] b, input logic [7:0] d);
    @(posedge core_clk);
    {cmd_valid, cmd_op, cmd_addr, cmd_bits, cmd_data} <= {1'b1, op, a, b, d};
    @(posedge core_clk);
    // Released address, bits and data invert so a stale value is never mistaken for live; cmd_op holds
    {cmd_valid, cmd_addr, cmd_bits, cmd_data} <= {1'b0, ~a, ~b, ~d};
  endtask
  task automatic modify(input logic [2:0] op, input logic [23:0] a,
                        input logic [15:0] b, input logic [7:0] d);
    issue(3'h0, 24'h0, 16'h8, 8'h0);
    issue(op, a, b, d);
  endtask
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Directed bench for the flash sector write-protect block
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_defs.vh"
module tb;
  logic             core_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             quad_mode = 1'b0;
  logic             wp_pin_n = 1'b1;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [4:0]       reg_addr = 5'h00;
  logic [7:0]       reg_wdata = 8'h00;
  wire logic        cmd_valid, verdict_valid, verdict_grant, top_bottom;
  wire logic        write_enable_latch, protect_size_bit0;
  wire logic        protect_size_bit1, protect_size_bit2;
  wire logic [2:0]  cmd_op, verdict_reason, verdict_op;
  wire logic [23:0] cmd_addr;
  wire logic [15:0] cmd_bits;
  wire logic [7:0]  cmd_data, reg_rdata;
  wire logic [9:0]  verdict_subsector;
  int               err_total = 0;
  int               check_count = 0;
  flash_sector_write_protect u_flash_sector_write_protect (.*);
  spi_host_model u_spi_host_model (.*);
  always #5 core_clk = ~core_clk;
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge core_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk({2'h0, reg_rdata}, {2'h0, e});
  endtask
  task automatic mv(input logic we, input logic [2:0] op, input logic [23:0] a,
                    input logic [15:0] b, input logic [2:0] why,
                    input logic [7:0] d = 8'h00);
    if (we) begin
      u_spi_host_model.modify(op, a, b, d);
    end else begin
      u_spi_host_model.issue(op, a, b, d);
    end
    #1 chk({6'h0, verdict_grant, verdict_reason}, {6'h0, why == 3'h0, why});
  endtask
  task automatic t_gates;
    rd(5'h00, 8'h02);
    wr(5'h14, 8'hff);
    rd(5'h14, 8'h00);
    for (int op = 2; op < 8; op++) begin
      mv(1'b1, op[2:0], 24'h0, 16'h1f, `WHY_FRAMING);
    end
    mv(1'b0, `OP_WRITE_DISABLE, 24'h0, 16'h8, `WHY_OK);
    mv(1'b0, `OP_PROGRAM, 24'h0, 16'h20, `WHY_NO_WEL);
    mv(1'b0, `OP_SECTOR_ERASE, 24'h0, 16'h20, `WHY_NO_WEL);
    mv(1'b1, `OP_PROGRAM, 24'h0, 16'h28, `WHY_OK);
  endtask
  task automatic t_area;
    int         n;
    logic [5:0] p;
    logic [5:0] q;
    logic [7:0] sd;
    for (int t = 0; t < 2; t++) begin
      for (int c = 1; c < 8; c++) begin
        n = (c == 7) ? 64 : 1 << (c - 1);
        p = 6'((t != 0) ? n - 1 : 64 - n);
        q = 6'((t != 0) ? n : 63 - n);
        sd = {2'b0, t[0], c[2:0], 2'b0};
        mv(1'b1, `OP_WRITE_STATUS, 24'h0, 16'h10, `WHY_OK, sd);
        rd(5'h00, sd | 8'h02);
        mv(1'b1, `OP_PROGRAM, {2'b0, p, 16'h0}, 16'h28, `WHY_AREA);
        mv(1'b1, `OP_BULK_ERASE, 24'h0, 16'h8, `WHY_AREA);
        if (c != 7) begin
          mv(1'b1, `OP_SUBSECT_ERASE, {2'b0, q, 16'hf000}, 16'h20, `WHY_OK);
        end
      end
    end
    mv(1'b1, `OP_WRITE_STATUS, 24'h0, 16'h10, `WHY_OK);
  endtask
  task automatic t_wp;
    @(posedge core_clk) wp_pin_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    mv(1'b1, `OP_WRITE_STATUS, 24'h0, 16'h10, `WHY_WP_PIN, 8'h1c);
    @(posedge core_clk) quad_mode <= 1'b1;
    mv(1'b1, `OP_WRITE_STATUS, 24'h0, 16'h10, `WHY_OK);
    @(posedge core_clk) quad_mode <= 1'b0;
    rd(`CTRL_ADDR, 8'h01);
    wr(`CTRL_ADDR, 8'h00);
    mv(1'b1, `OP_WRITE_STATUS, 24'h0, 16'h10, `WHY_OK);
    wr(`CTRL_ADDR, 8'h01);
    @(posedge core_clk) wp_pin_n <= 1'b1;
  endtask
  task automatic t_locks;
    mv(1'b1, `OP_WRITE_LOCK, 24'h050000, 16'h10, `WHY_OK, 8'h01);
    mv(1'b1, `OP_SUBSECT_ERASE, 24'h05f123, 16'h20, `WHY_LOCKED);
    chk(verdict_subsector, 10'h05f);
    mv(1'b1, `OP_PROGRAM, 24'h04ffff, 16'h28, `WHY_OK);
    mv(1'b1, `OP_BULK_ERASE, 24'h0, 16'h8, `WHY_LOCKED);
    mv(1'b1, `OP_WRITE_LOCK, 24'h050000, 16'h10, `WHY_OK, 8'h03);
    mv(1'b1, `OP_WRITE_LOCK, 24'h05ffff, 16'h10, `WHY_LOCKDOWN);
    rd(5'h0c, 8'h76);
    wr(5'h04, 8'h05);
    rd(5'h04, 8'h05);
    rd(5'h08, 8'h03);
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    wr(5'h04, 8'h05);
    rd(5'h08, 8'h00);
    mv(1'b1, `OP_PROGRAM, 24'h050000, 16'h28, `WHY_OK);
  endtask
  task automatic finish_test;
    $display("mismatches %0d of %0d checks", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    // The pin synchroniser needs two edges before its level is trusted
    repeat (2) @(posedge core_clk);
    t_gates;
    t_area;
    t_wp;
    t_locks;
    finish_test;
  end
endmodule
`default_nettype wire
